// *** rtl/pms_sequencer.sv ***
// Mode and reset sequencer of a jitter-cleaning clock multiplier.
// Assumes a host that waits for cfg_ready, and a word-wide nonvolatile_store read port
// answering in the same cycle as the address.
// Overview of operation
// - Software picks loop bandwidth 0.1 Hz-4 kHz
// - Quick-acquire uses temporary bandwidth during acquisition
// - Temporary bandwidth spans 100 Hz-4 kHz
// - Normal bandwidth restored when acquisition ends
// - After init: freerun, acquire, locked or holdover
// - Power-up copies defaults from nonvolatile store
// - Serial interface unused until init completes
// - Output clocks held off until init done
// - Hard reset reruns download and settling as at power-up
// - Hard reset from pin or control bit
// - Soft reset applies writes, skips download
// - Manual or automatic reference input selection
// - Frequency config writable and storable nonvolatile
// - Freerun entered automatically after init
// - Valid input starts lock acquisition automatically
// - Holdover when selected invalid, none valid
// - Holdover left when an input returns
`timescale 1ns/1ps

module pms_sequencer
	import pms_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic hard_reset_pin_n,
	// Host staging side
	input wire logic host_wr,
	input wire pms_cfg_t host_cfg,
	input wire logic hard_reset_set,
	input wire logic soft_reset,
	input wire logic store_req,
	// Nonvolatile store
	output logic [NV_AW-1:0] nv_addr,
	output logic nv_rd,
	input wire logic [CFG_W-1:0] nv_data,
	output logic nv_wr,
	output logic [CFG_W-1:0] nv_wdata,
	// Loop status
	input wire logic [INPUTS-1:0] in_valid,
	input wire logic pll_locked,
	// Status and control out
	output logic cfg_ready,
	output logic out_clk_en,
	output logic hard_reset_bit,
	output pms_mode_t mode,
	output logic [BW_W-1:0] active_bw,
	output logic [SEL_W-1:0] sel_input,
	output pms_cfg_t live_cfg
);

	logic pin_s1_reg, pin_s2_reg;
	logic pin_s1_next, pin_s2_next;
	logic hrb_reg, hrb_next;
	pms_seq_t seq_reg, seq_next;
	logic [NV_AW-1:0] addr_reg, addr_next;
	logic rd_reg, rd_next;
	logic [$clog2(INIT_SETTLE_CYC+1)-1:0] cnt_reg, cnt_next;
	logic [CFG_W-1:0] dl_reg [NV_WORDS];
	logic [CFG_W-1:0] dl_next [NV_WORDS];
	pms_cfg_t stage_reg, stage_next, live_reg, live_next;
	pms_mode_t mode_reg, mode_next;
	logic [SEL_W-1:0] sel_reg, sel_next;
	logic [BW_W-1:0] bw_reg, bw_next;
	logic ready_reg, ready_next, oen_reg, oen_next;
	logic nvw_reg, nvw_next;
	logic [CFG_W-1:0] nvd_reg, nvd_next;
	logic hard_go;
	logic any_valid;
	logic [SEL_W-1:0] pick;
	pms_cfg_t nv_cfg;

	function automatic logic [BW_W-1:0] clampbw(input logic [BW_W-1:0] v, input logic [BW_W-1:0] lo,
		input logic [BW_W-1:0] hi);
		if (v < lo)
			return lo;
		else if (v > hi)
			return hi;
		return v;
	endfunction

	// Pin reaches logic only through the second flop
	always_comb
	begin
		pin_s1_next = hard_reset_pin_n;
		pin_s2_next = pin_s1_reg;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pin_s1_reg <= 1'b1;
			pin_s2_reg <= 1'b1;
		end
		else
		begin
			pin_s1_reg <= pin_s1_next;
			pin_s2_reg <= pin_s2_next;
		end
	end

	assign hard_go = !pin_s2_reg || hrb_reg;

	// Store words 0..2 hold the configuration image; the rest are read but unused here
	always_comb
	begin
		nv_cfg = {dl_reg[0][BW_W-1:0], dl_reg[1][BW_W-1:0], dl_reg[1][8], dl_reg[1][9],
			dl_reg[1][11:10], dl_reg[2]};
	end

	// Download, settle, then run
	always_comb
	begin
		seq_next = seq_reg;
		addr_next = addr_reg;
		rd_next = 1'b0;
		cnt_next = cnt_reg;
		hrb_next = hrb_reg;
		ready_next = ready_reg;
		oen_next = oen_reg;
		for (int i = 0; i < NV_WORDS; i++)
			dl_next[i] = dl_reg[i];
		if (hard_go && seq_reg == PMS_SEQ_RUN)
		begin
			// Restart as at power-up; the bit stays set until settling is over
			seq_next = PMS_SEQ_LOAD;
			addr_next = '0;
			ready_next = 1'b0;
			oen_next = 1'b0;
		end
		else
		begin
			case (seq_reg)
				PMS_SEQ_LOAD:
				begin
					rd_next = 1'b1;
					if (rd_reg)
					begin
						dl_next[addr_reg] = nv_data;
						if (addr_reg == NV_AW'(NV_WORDS - 1))
						begin
							rd_next = 1'b0;
							seq_next = PMS_SEQ_SETTLE;
							cnt_next = '0;
						end
						else
							addr_next = addr_reg + 1'b1;
					end
				end
				PMS_SEQ_SETTLE:
				begin
					cnt_next = cnt_reg + 1'b1;
					if (cnt_reg == ($bits(cnt_reg))'(INIT_SETTLE_CYC - 1) && pin_s2_reg)
					begin
						seq_next = PMS_SEQ_RUN;
						ready_next = 1'b1;
						oen_next = 1'b1;
						hrb_next = 1'b0;
					end
					else if (!pin_s2_reg)
						cnt_next = '0;
				end
				PMS_SEQ_RUN:
				begin
					if (hard_reset_set && ready_reg)
						hrb_next = 1'b1;
				end
				default:
					seq_next = PMS_SEQ_LOAD;
			endcase
		end
	end

	// Host writes land in staging; soft reset makes them live, download replaces both with the store image
	always_comb
	begin
		stage_next = stage_reg;
		live_next = live_reg;
		nvw_next = 1'b0;
		nvd_next = nvd_reg;
		if (seq_reg == PMS_SEQ_SETTLE)
		begin
			stage_next = nv_cfg;
			stage_next.loop_bw = clampbw(nv_cfg.loop_bw, BW_CODE_MIN, BW_CODE_MAX);
			stage_next.fast_bw = clampbw(nv_cfg.fast_bw, FBW_CODE_MIN, FBW_CODE_MAX);
			live_next = stage_next;
		end
		else if (seq_reg == PMS_SEQ_RUN && ready_reg)
		begin
			if (host_wr)
			begin
				stage_next = host_cfg;
				stage_next.loop_bw = clampbw(host_cfg.loop_bw, BW_CODE_MIN, BW_CODE_MAX);
				stage_next.fast_bw = clampbw(host_cfg.fast_bw, FBW_CODE_MIN, FBW_CODE_MAX);
			end
			if (soft_reset)
				live_next = stage_reg;
			if (store_req)
			begin
				nvw_next = 1'b1;
				nvd_next = stage_reg.freq_cfg;
			end
		end
	end

	// Reference choice: lowest valid input when automatic, register value otherwise
	always_comb
	begin
		any_valid = |in_valid;
		pick = sel_reg;
		for (int i = INPUTS - 1; i >= 0; i--)
			if (in_valid[i])
				pick = SEL_W'(i);
	end

	always_comb
	begin
		mode_next = mode_reg;
		sel_next = live_reg.auto_sel ? pick : live_reg.man_sel;
		bw_next = live_reg.loop_bw;
		case (mode_reg)
			PMS_INIT:
				if (seq_reg == PMS_SEQ_RUN)
					mode_next = PMS_FREERUN;
			PMS_FREERUN:
				if (in_valid[sel_next])
					mode_next = PMS_ACQUIRE;
			PMS_ACQUIRE:
			begin
				// With automatic choice another valid input keeps acquisition going
				if (!in_valid[sel_reg] && !(any_valid && live_reg.auto_sel))
					mode_next = PMS_HOLDOVER;
				else if (pll_locked && in_valid[sel_reg])
					mode_next = PMS_LOCKED;
				else if (live_reg.fast_en)
					bw_next = live_reg.fast_bw;
			end
			PMS_LOCKED:
				if (!in_valid[sel_reg])
					mode_next = any_valid && live_reg.auto_sel ? PMS_ACQUIRE : PMS_HOLDOVER;
			PMS_HOLDOVER:
				if (in_valid[sel_next])
					mode_next = PMS_ACQUIRE;
			default:
				mode_next = PMS_INIT;
		endcase
		if (seq_reg != PMS_SEQ_RUN || hard_go)
			mode_next = PMS_INIT;
		if (mode_next == PMS_ACQUIRE && mode_reg != PMS_ACQUIRE && live_reg.fast_en)
			bw_next = live_reg.fast_bw;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			hrb_reg <= 1'b0;
			seq_reg <= PMS_SEQ_LOAD;
			addr_reg <= '0;
			rd_reg <= 1'b0;
			cnt_reg <= '0;
			for (int i = 0; i < NV_WORDS; i++)
				dl_reg[i] <= CFG_RESET;
			stage_reg <= '{BW_RESET, FBW_RESET, 1'b0, 1'b0, SEL_RESET, CFG_RESET};
			live_reg <= '{BW_RESET, FBW_RESET, 1'b0, 1'b0, SEL_RESET, CFG_RESET};
			mode_reg <= PMS_INIT;
			sel_reg <= SEL_RESET;
			bw_reg <= BW_RESET;
			ready_reg <= 1'b0;
			oen_reg <= 1'b0;
			nvw_reg <= 1'b0;
			nvd_reg <= CFG_RESET;
		end
		else
		begin
			hrb_reg <= hrb_next;
			seq_reg <= seq_next;
			addr_reg <= addr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
			dl_reg <= dl_next;
			stage_reg <= stage_next;
			live_reg <= live_next;
			mode_reg <= mode_next;
			sel_reg <= sel_next;
			bw_reg <= bw_next;
			ready_reg <= ready_next;
			oen_reg <= oen_next;
			nvw_reg <= nvw_next;
			nvd_reg <= nvd_next;
		end
	end

	assign nv_addr = addr_reg;
	assign nv_rd = rd_reg;
	assign nv_wr = nvw_reg;
	assign nv_wdata = nvd_reg;
	assign cfg_ready = ready_reg;
	assign out_clk_en = oen_reg;
	assign hard_reset_bit = hrb_reg;
	assign mode = mode_reg;
	assign active_bw = bw_reg;
	assign sel_input = sel_reg;
	assign live_cfg = live_reg;

endmodule

// *** rtl/pms_pkg.sv ***
// Package for the clock mode and reset sequencer: constants, mode enumeration, carriers.
// Assumes a single 20 MHz control clock.
package pms_pkg;

	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned BW_W = 6;
	localparam int unsigned SEL_W = 2;
	localparam int unsigned CFG_W = 16;
	localparam int unsigned NV_AW = 4;
	localparam int unsigned NV_WORDS = 16;
	localparam int unsigned INPUTS = 4;

	// Loop bandwidth codes: 0 is 0.1 Hz, max code is 4 kHz
	localparam logic [BW_W-1:0] BW_CODE_MIN = 6'h00;
	localparam logic [BW_W-1:0] BW_CODE_MAX = 6'h2f;
	// Acquisition bandwidth codes: 100 Hz up to 4 kHz
	localparam logic [BW_W-1:0] FBW_CODE_MIN = 6'h1e;
	localparam logic [BW_W-1:0] FBW_CODE_MAX = 6'h2f;
	localparam logic [BW_W-1:0] BW_RESET = 6'h00;
	localparam logic [BW_W-1:0] FBW_RESET = 6'h1e;
	localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;
	localparam logic [SEL_W-1:0] SEL_RESET = 2'h0;

	// Cycles of settling after the store download
	localparam int unsigned INIT_SETTLE_NS = 1000;
	localparam int unsigned INIT_SETTLE_CYC = (INIT_SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000;

	typedef enum logic [2:0]
	{
		PMS_INIT = 3'h0,
		PMS_FREERUN = 3'h1,
		PMS_ACQUIRE = 3'h2,
		PMS_LOCKED = 3'h3,
		PMS_HOLDOVER = 3'h4
	} pms_mode_t;

	typedef enum logic [1:0]
	{
		PMS_SEQ_LOAD = 2'h0,
		PMS_SEQ_SETTLE = 2'h1,
		PMS_SEQ_RUN = 2'h2
	} pms_seq_t;

	typedef struct packed
	{
		logic [BW_W-1:0] loop_bw;
		logic [BW_W-1:0] fast_bw;
		logic fast_en;
		logic auto_sel;
		logic [SEL_W-1:0] man_sel;
		logic [CFG_W-1:0] freq_cfg;
	} pms_cfg_t;

endpackage

// *** verif/pms_nv_model.sv ***
// Nonvolatile store model holding a fixed power-up image.
// Assumes the design samples read data in the cycle it presents the address; writes land in the frequency word.
`timescale 1ns/1ps

module pms_nv_model
	import pms_pkg::*;
(
	// Clock
	input wire logic clk,
	// Store port
	input wire logic [NV_AW-1:0] nv_addr,
	input wire logic nv_rd,
	output logic [CFG_W-1:0] nv_data,
	input wire logic nv_wr,
	input wire logic [CFG_W-1:0] nv_wdata
);
	logic [CFG_W-1:0] mem [NV_WORDS];

	initial
	begin
		foreach (mem[i])
			mem[i] = 16'h0000;
		mem[0] = 16'h0005;
		mem[1] = 16'h0520;
		mem[2] = 16'hbeef;
	end

	// Read is combinational; outside a read the lines show the inverse so stale data never looks valid
	always_comb
		nv_data = nv_rd ? mem[nv_addr] : ~mem[nv_addr];

	always @(posedge clk)
	begin
		if (nv_wr)
			mem[2] <= nv_wdata;
	end
endmodule

// *** verif/pms_sequencer_checker.sv ***
// Port-level checker for the mode and reset sequencer.
// Assumes the single clk domain with nrst as async reset.
`timescale 1ns/1ps

module pms_sequencer_checker
	import pms_pkg::*;
(
	// Watched ports
	input wire logic clk,
	input wire logic nrst,
	input wire logic hard_reset_pin_n,
	input wire logic hard_reset_set,
	input wire logic store_req,
	input wire logic [INPUTS-1:0] in_valid,
	input wire logic nv_wr,
	input wire logic cfg_ready,
	input wire logic out_clk_en,
	input wire logic hard_reset_bit,
	input wire pms_mode_t mode,
	input wire logic [BW_W-1:0] active_bw,
	input wire logic [SEL_W-1:0] sel_input,
	input wire pms_cfg_t live_cfg
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	property p_clk_off; !cfg_ready |-> !out_clk_en; endproperty
	a_clk_off: assert property (p_clk_off) else $error("clocks enabled before init");
	property p_modes; cfg_ready && $past(cfg_ready) |-> mode inside {[PMS_FREERUN:PMS_HOLDOVER]}; endproperty
	a_modes: assert property (p_modes) else $error("mode outside the four");
	property p_fast; mode == PMS_ACQUIRE && live_cfg.fast_en && $stable(mode) && $stable(live_cfg)
		|-> active_bw == live_cfg.fast_bw; endproperty
	a_fast: assert property (p_fast) else $error("acquire bandwidth wrong");
	property p_norm; mode != PMS_ACQUIRE && $stable(mode) && $stable(live_cfg) |-> active_bw == live_cfg.loop_bw;
	endproperty
	a_norm: assert property (p_norm) else $error("normal bandwidth wrong");
	property p_range; live_cfg.loop_bw <= BW_CODE_MAX && live_cfg.fast_bw >= FBW_CODE_MIN
		&& live_cfg.fast_bw <= FBW_CODE_MAX; endproperty
	a_range: assert property (p_range) else $error("bandwidth code out of span");
	property p_store; store_req && cfg_ready |=> nv_wr; endproperty
	a_store: assert property (p_store) else $error("store write missing");
	property p_hrst; hard_reset_set && cfg_ready |-> ##[1:3] !cfg_ready; endproperty
	a_hrst: assert property (p_hrst) else $error("hard reset bit ignored");
	property p_pin; !hard_reset_pin_n [*4] |-> !cfg_ready; endproperty
	a_pin: assert property (p_pin) else $error("reset pin ignored");
	property p_bitclr; $rose(cfg_ready) |-> ##[0:1] !hard_reset_bit; endproperty
	a_bitclr: assert property (p_bitclr) else $error("hard reset bit stuck");
	property p_free; $rose(cfg_ready) |=> mode == PMS_FREERUN; endproperty
	a_free: assert property (p_free) else $error("no freerun after init");
	property p_acq; cfg_ready && mode == PMS_FREERUN && in_valid[sel_input] |-> ##[1:2] mode == PMS_ACQUIRE;
	endproperty
	a_acq: assert property (p_acq) else $error("no acquire on valid input");
	property p_hold; mode == PMS_ACQUIRE && in_valid == 4'h0 |-> ##[1:2] mode == PMS_HOLDOVER; endproperty
	a_hold: assert property (p_hold) else $error("no holdover");
	property p_exit; mode == PMS_HOLDOVER && in_valid[sel_input] |-> ##[1:2] mode == PMS_ACQUIRE; endproperty
	a_exit: assert property (p_exit) else $error("holdover not left");

	c_lock: cover property (mode == PMS_LOCKED);
	c_hold: cover property (mode == PMS_HOLDOVER);
	c_hrst: cover property (hard_reset_set && cfg_ready);
endmodule

bind pms_sequencer pms_sequencer_checker i_pms_sequencer_checker (.clk(clk), .nrst(nrst),
	.hard_reset_pin_n(hard_reset_pin_n), .hard_reset_set(hard_reset_set), .store_req(store_req),
	.in_valid(in_valid), .nv_wr(nv_wr), .cfg_ready(cfg_ready), .out_clk_en(out_clk_en),
	.hard_reset_bit(hard_reset_bit), .mode(mode), .active_bw(active_bw), .sel_input(sel_input),
	.live_cfg(live_cfg));

// *** verif/pms_sequencer_tb.sv ***
// Testbench for the mode and reset sequencer with a store model.
// Assumes a 20 MHz clock; inputs change on rising edges, outputs checked on falling edges.
`timescale 1ns/1ps

module pms_sequencer_tb;
	import pms_pkg::*;
	logic clk, nrst, hard_reset_pin_n, host_wr, hard_reset_set, soft_reset, store_req, pll_locked;
	logic nv_rd, nv_wr, cfg_ready, out_clk_en, hard_reset_bit;
	logic [NV_AW-1:0] nv_addr;
	logic [CFG_W-1:0] nv_data, nv_wdata;
	logic [INPUTS-1:0] in_valid;
	logic [BW_W-1:0] active_bw;
	logic [SEL_W-1:0] sel_input;
	pms_cfg_t host_cfg, live_cfg;
	pms_mode_t mode;
	int error_cnt = 0;
	int num_checks = 0;
	localparam pms_cfg_t IMG = {6'h05, 6'h20, 1'b1, 1'b0, 2'h1, 16'hbeef};
	localparam pms_cfg_t MAN = {6'h3f, 6'h00, 1'b1, 1'b0, 2'h1, 16'h1234};
	localparam pms_cfg_t AUT = {6'h3f, 6'h00, 1'b1, 1'b1, 2'h1, 16'h1234};

	pms_sequencer i_pms_sequencer (.clk(clk), .nrst(nrst), .hard_reset_pin_n(hard_reset_pin_n),
		.host_wr(host_wr), .host_cfg(host_cfg), .hard_reset_set(hard_reset_set), .soft_reset(soft_reset),
		.store_req(store_req), .nv_addr(nv_addr), .nv_rd(nv_rd), .nv_data(nv_data), .nv_wr(nv_wr),
		.nv_wdata(nv_wdata), .in_valid(in_valid), .pll_locked(pll_locked), .cfg_ready(cfg_ready),
		.out_clk_en(out_clk_en), .hard_reset_bit(hard_reset_bit), .mode(mode), .active_bw(active_bw),
		.sel_input(sel_input), .live_cfg(live_cfg));
	pms_nv_model i_pms_nv_model (.clk(clk), .nv_addr(nv_addr), .nv_rd(nv_rd), .nv_data(nv_data),
		.nv_wr(nv_wr), .nv_wdata(nv_wdata));

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task step(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	// Pulses {host_wr, soft_reset, store_req, hard_reset_set} for one sampled edge
	task host(input logic [3:0] p, input pms_cfg_t c);
		@(posedge clk);
		{host_wr, soft_reset, store_req, hard_reset_set} <= p;
		host_cfg <= c;
		@(posedge clk);
		{host_wr, soft_reset, store_req, hard_reset_set} <= 4'h0;
	endtask

	task wait_ready;
		repeat (200)
		begin
			@(negedge clk);
			if (cfg_ready === 1'b1)
				break;
		end
		chk("cfg_ready", cfg_ready, 1'b1);
	endtask

	task end_of_test;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		end_of_test();
	end

	initial
	begin
		{nrst, hard_reset_pin_n, host_wr, hard_reset_set, soft_reset, store_req, pll_locked} = 7'b0100000;
		in_valid = 4'h0;
		host_cfg = MAN;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		host(4'b1000, MAN);
		step(0);
		chk("clk_en", out_clk_en, 1'b0);
		wait_ready();
		step(1);
		chk("mode", mode, PMS_FREERUN);
		chk("live", live_cfg, IMG);
		host(4'b0100, MAN);
		step(1);
		chk("live", live_cfg, IMG);
		host(4'b1000, MAN);
		step(1);
		chk("live", live_cfg, IMG);
		host(4'b0100, MAN);
		step(1);
		chk("live", live_cfg, {6'h2f, 6'h1e, 1'b1, 1'b0, 2'h1, 16'h1234});
		chk("ready", cfg_ready, 1'b1);
		@(posedge clk);
		in_valid <= 4'h2;
		step(3);
		chk("mode", mode, PMS_ACQUIRE);
		chk("bw", active_bw, 6'h1e);
		@(posedge clk);
		pll_locked <= 1'b1;
		step(3);
		chk("mode", mode, PMS_LOCKED);
		chk("bw", active_bw, 6'h2f);
		@(posedge clk);
		{in_valid, pll_locked} <= 5'h00;
		step(4);
		chk("mode", mode, PMS_HOLDOVER);
		@(posedge clk);
		in_valid <= 4'h2;
		step(3);
		chk("mode", mode, PMS_ACQUIRE);
		@(posedge clk);
		in_valid <= 4'h0;
		host(4'b1000, AUT);
		host(4'b0100, AUT);
		in_valid <= 4'hc;
		step(4);
		chk("sel", sel_input, 2'h2);
		@(posedge clk);
		in_valid <= 4'h0;
		host(4'b0010, AUT);
		repeat (4)
		begin
			@(negedge clk);
			if (nv_wr === 1'b1)
				break;
		end
		chk("nv_wr", nv_wr, 1'b1);
		chk("nv_wdata", nv_wdata, 16'h1234);
		host(4'b0001, AUT);
		step(0);
		chk("hbit", hard_reset_bit, 1'b1);
		step(3);
		chk("ready", {cfg_ready, out_clk_en}, 2'h0);
		wait_ready();
		chk("hbit", hard_reset_bit, 1'b0);
		chk("live", live_cfg, {6'h05, 6'h20, 1'b1, 1'b0, 2'h1, 16'h1234});
		@(posedge clk);
		hard_reset_pin_n <= 1'b0;
		step(5);
		chk("ready", cfg_ready, 1'b0);
		@(posedge clk);
		hard_reset_pin_n <= 1'b1;
		wait_ready();
		end_of_test();
	end
endmodule
